// >>> rtl/ram_init_loader_pkg.sv
// Constants shared by the serial RAM init loader and its word FIFO.
// Assumes a single core clock domain; link pins are sampled, not used as clocks.
package ram_init_loader_pkg;
  localparam int          DATA_W_DEF   = 8;
  localparam int          ADDR_W_DEF   = 8;
  localparam int          BLOCKS_DEF   = 4;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [1:0]  SYNC_RST     = 2'h0;
  localparam logic        CSEL_RST     = 1'h0;
endpackage : ram_init_loader_pkg

// >>> rtl/word_fifo.sv
// Small valid/ready FIFO held in flip-flops.
// Assumes one clock; both sides handshake on the same edge.
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  // Compare at full counter width; a PW-bit cast of DEPTH wraps to zero
  assign inReady  = (count_r != (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + PW'(1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + PW'(1);
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : word_fifo

// >>> rtl/ram_init_loader.sv
// Serial RAM initialisation loader: shifts words in from the user JTAG port,
// buffers them, and writes them to a set of RAM blocks.
// Assumes the JTAG access macro pins arrive asynchronously to core_clk.
//
// Behaviour
// [R01] Serial bits from the user serial data output are assembled into words for the RAM write ports.
// [R02] The data shift register is exactly DATA_W bits, the RAM data width.
// [R03] Shifting happens on edges of the data-register clock, found by sampling it.
// [R04] A word is passed on only once all of its bits have been shifted in.
// [R05] Write data is held in a pipeline register aligned with address, select and write clock.
// [R06] Address comes from a second shift register under the address instruction or from a counter.
// [R07] One chip select per RAM block, moved along as a ring.
// [R08] The loader drives the RAM write clock, qualifying data, address and select.
// [R09] The host must load the instruction that routes shifted data to user logic.
// [R10] Normal design logic may write the RAM whenever the loader is idle.
// [R11] Without useExtAddr the counter advances after each word and wraps into the next block after the last address.
`timescale 1ns/10ps
module ram_init_loader
  import ram_init_loader_pkg::*;
#(
  parameter int DATA_W = ram_init_loader_pkg::DATA_W_DEF,
  parameter int ADDR_W = ram_init_loader_pkg::ADDR_W_DEF,
  parameter int BLOCKS = ram_init_loader_pkg::BLOCKS_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              userDataRegisterClock,
  input  wire logic              userSerialDataOut,
  input  wire logic              userShiftEnable,
  input  wire logic              userAddrSelect,
  input  wire logic              userUpdate,
  input  wire logic              useExtAddr,
  input  wire logic              userWrEn,
  input  wire logic [ADDR_W-1:0] userWrAddr,
  input  wire logic [DATA_W-1:0] userWrData,
  input  wire logic [BLOCKS-1:0] userChipSel,
  output logic      [DATA_W-1:0] ramWrData,
  output logic      [ADDR_W-1:0] ramWrAddr,
  output logic      [BLOCKS-1:0] ramChipSel,
  output logic                   ramWrClk,
  output logic                   loadBusy
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one feeds only stage two
  logic [1:0] ckSync_r, datSync_r, shSync_r, asSync_r, upSync_r;
  logic       ckPrev_r;
  logic       drckRise;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ckSync_r  <= SYNC_RST;
      datSync_r <= SYNC_RST;
      shSync_r  <= SYNC_RST;
      asSync_r  <= SYNC_RST;
      upSync_r  <= SYNC_RST;
      ckPrev_r  <= 1'h0;
    end else begin
      ckSync_r  <= {ckSync_r[0], userDataRegisterClock};
      datSync_r <= {datSync_r[0], userSerialDataOut};
      shSync_r  <= {shSync_r[0], userShiftEnable};
      asSync_r  <= {asSync_r[0], userAddrSelect};
      upSync_r  <= {upSync_r[0], userUpdate};
      ckPrev_r  <= ckSync_r[1];
    end
  end

  assign drckRise = ckSync_r[1] && !ckPrev_r; // R03

  ////////////////////////////////////////////////////////////////////////
  // Data and address shift registers
  localparam int BW = $clog2(DATA_W + 1);
  logic [DATA_W-1:0] dataShift_r;
  logic [ADDR_W-1:0] addrShift_r;
  logic [BW-1:0]     bitCnt_r;
  logic              wordDone;
  logic              fifoInReady;
  logic              shiftData;

  // Hold only the word-completing shift while FIFO is full; host pacing must leave room
  assign shiftData = drckRise && shSync_r[1] && !asSync_r[1];
  assign wordDone  = shiftData && (bitCnt_r == BW'(DATA_W - 1)); // R04

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dataShift_r <= '0;
      addrShift_r <= '0;
      bitCnt_r    <= '0;
    end else begin
      if (shiftData && (fifoInReady || !wordDone)) begin
        dataShift_r <= {datSync_r[1], dataShift_r[DATA_W-1:1]}; // R01 R02
        bitCnt_r    <= wordDone ? '0 : bitCnt_r + BW'(1);
      end
      if (drckRise && shSync_r[1] && asSync_r[1]) begin
        addrShift_r <= {datSync_r[1], addrShift_r[ADDR_W-1:1]}; // R06
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word FIFO
  logic [DATA_W-1:0] fifoOutData;
  logic              fifoOutValid;
  logic              wrPhase_r;
  logic              fifoPop;

  assign fifoPop = fifoOutValid && !wrPhase_r;

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inData   ({datSync_r[1], dataShift_r[DATA_W-1:1]}),
    .inValid  (wordDone),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address counter and ring select
  logic [ADDR_W-1:0] addrCnt_r;
  logic [BLOCKS-1:0] ring_r;
  logic              extLatch_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addrCnt_r  <= '0;
      ring_r     <= {{(BLOCKS-1){CSEL_RST}}, 1'h1};
      extLatch_r <= 1'h0;
    end else begin
      extLatch_r <= upSync_r[1];
      if (upSync_r[1] && !extLatch_r && useExtAddr) begin
        addrCnt_r <= addrShift_r; // R06
      end else if (fifoPop && !useExtAddr) begin
        addrCnt_r <= addrCnt_r + ADDR_W'(1); // R11
        if (&addrCnt_r) begin
          ring_r <= {ring_r[BLOCKS-2:0], ring_r[BLOCKS-1]}; // R07 R11
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RAM write port: setup cycle, then write clock high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramWrData  <= '0;
      ramWrAddr  <= '0;
      ramChipSel <= '0;
      ramWrClk   <= 1'h0;
      wrPhase_r  <= 1'h0;
      loadBusy   <= 1'h0;
    end else begin
      loadBusy <= fifoOutValid || wrPhase_r;
      if (fifoPop) begin
        ramWrData  <= fifoOutData; // R05
        ramWrAddr  <= useExtAddr ? addrShift_r : addrCnt_r; // R06
        ramChipSel <= useExtAddr ? ring_r : ring_r; // R07
        ramWrClk   <= 1'h0;
        wrPhase_r  <= 1'h1;
      end else if (wrPhase_r) begin
        ramWrClk  <= 1'h1; // R08
        wrPhase_r <= 1'h0;
      end else if (userWrEn) begin
        ramWrData  <= userWrData; // R10
        ramWrAddr  <= userWrAddr;
        ramChipSel <= userChipSel;
        ramWrClk   <= !ramWrClk;
      end else begin
        ramWrClk   <= 1'h0;
        ramChipSel <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Separate tally of accepted data bits, so the word check
  // does not lean on the counter that produces the word
  logic [BW-1:0] bitsSeen_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bitsSeen_r <= '0;
    end else if (wordDone && fifoInReady) begin
      bitsSeen_r <= '0;
    end else if (shiftData && !wordDone) begin
      bitsSeen_r <= bitsSeen_r + BW'(1);
    end
  end

  // Write cycle in two steps: setup with clock low, then clock high
  sequence wrSetup_s;
    !ramWrClk && wrPhase_r;
  endsequence

  sequence wrStrobe_s;
    ramWrClk && !wrPhase_r;
  endsequence

  // Busy must cover both steps of the write
  sequence busyHeld_s;
    loadBusy [*2];
  endsequence

  AST_WCLK_AFTER_SETUP: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
    fifoPop |=> wrSetup_s ##1 wrStrobe_s) else $error("write clock not one cycle after setup");
  AST_DATA_FROM_FIFO: assert property (@(posedge core_clk) disable iff (!rst_b) // R05
    fifoPop |=> ramWrData == $past(fifoOutData)) else $error("write data mismatch");
  AST_ADDR_STEP: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
    fifoPop && !useExtAddr && !(upSync_r[1] && !extLatch_r) |=> addrCnt_r == $past(addrCnt_r) + ADDR_W'(1))
    else $error("address counter did not advance");
  AST_RING_ONEHOT: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
    $onehot(ring_r)) else $error("ring select not one-hot");
  AST_WORD_BITS: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
    wordDone && fifoInReady |-> bitsSeen_r == BW'(DATA_W - 1)) else $error("word passed before full");
  AST_SHIFT_ON_EDGE: assert property (@(posedge core_clk) disable iff (!rst_b) // R03
    $changed(bitCnt_r) |-> $past(drckRise)) else $error("shift without clock edge");
  AST_BITCNT_RANGE: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
    bitCnt_r < BW'(DATA_W)) else $error("bit count past word width");
  AST_BUSY_FLAG: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
    fifoPop |=> busyHeld_s) else $error("busy not held through write");
  AST_USER_WRITE: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
    userWrEn && !fifoOutValid && !wrPhase_r |=> ramWrAddr == $past(userWrAddr))
    else $error("user write address not taken");
endmodule : ram_init_loader

// >>> tb/jtag_host_model.sv
// Behavioural JTAG host that drives the user JTAG access macro pins.
// Assumes core_clk paces it; the DR clock idles low between frames.
`timescale 1ns/10ps
module jtag_host_model (
  input  wire logic core_clk,
  output logic      userDataRegisterClock,
  output logic      userSerialDataOut,
  output logic      userShiftEnable,
  output logic      userAddrSelect,
  output logic      userUpdate
);
  initial begin
    userDataRegisterClock = 1'h0;
    userSerialDataOut     = 1'h0;
    userShiftEnable       = 1'h0;
    userAddrSelect        = 1'h0;
    userUpdate            = 1'h0;
  end

  // 64 ns DR clock; data moves mid-low so the synchronised sample never races it
  task shift_bits(input logic [7:0] v, input int n, input logic toAddr);
    int i;
    userShiftEnable <= 1'h1;
    userAddrSelect  <= toAddr;
    for (i = 0; i < n; i++) begin
      repeat (2) @(posedge core_clk);
      userSerialDataOut <= v[i];
      repeat (2) @(posedge core_clk);
      userDataRegisterClock <= 1'h1;
      repeat (4) @(posedge core_clk);
      userDataRegisterClock <= 1'h0;
    end
    repeat (2) @(posedge core_clk);
    // Released line shows the inverse, not a stale copy
    userSerialDataOut <= ~v[n-1];
    userShiftEnable   <= 1'h0;
    userAddrSelect    <= 1'h0;
  endtask : shift_bits

  task pulse_update();
    @(posedge core_clk);
    userUpdate <= 1'h1;
    repeat (6) @(posedge core_clk);
    userUpdate <= 1'h0;
    repeat (6) @(posedge core_clk);
  endtask : pulse_update
endmodule : jtag_host_model

// >>> tb/ram_init_loader_bench.sv
// Self-checking bench for the serial RAM init loader.
// Assumes a 2-bit address so the ring select moves after four words.
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module ram_init_loader_bench;
  logic core_clk, rst_b, drClk, serOut, shEn, adSel, upd, useExtAddr, userWrEn, ramWrClk, loadBusy, wrClkQ;
  logic [1:0] userWrAddr, ramWrAddr;
  logic [7:0] userWrData, ramWrData;
  logic [3:0] userChipSel, ramChipSel;
  logic [7:0] seenData[$];
  logic [1:0] seenAddr[$];
  logic [3:0] seenSel[$];
  logic       seenBusy[$];
  int         nErrors, cmpCount;

  jtag_host_model jtag_host_model_i (.core_clk(core_clk), .userDataRegisterClock(drClk),
    .userSerialDataOut(serOut), .userShiftEnable(shEn), .userAddrSelect(adSel), .userUpdate(upd));
  ram_init_loader #(.DATA_W(8), .ADDR_W(2), .BLOCKS(4)) ram_init_loader_i (.core_clk(core_clk),
    .rst_b(rst_b), .userDataRegisterClock(drClk), .userSerialDataOut(serOut), .userShiftEnable(shEn),
    .userAddrSelect(adSel), .userUpdate(upd), .useExtAddr(useExtAddr), .userWrEn(userWrEn),
    .userWrAddr(userWrAddr), .userWrData(userWrData), .userChipSel(userChipSel), .ramWrData(ramWrData),
    .ramWrAddr(ramWrAddr), .ramChipSel(ramChipSel), .ramWrClk(ramWrClk), .loadBusy(loadBusy));

  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  // Every write clock rise captures what the RAM would store
  always @(posedge core_clk) begin
    wrClkQ <= ramWrClk;
    if (ramWrClk && !wrClkQ) begin
      seenData.push_back(ramWrData);
      seenAddr.push_back(ramWrAddr);
      seenSel.push_back(ramChipSel);
      seenBusy.push_back(loadBusy);
    end
  end

  task expect_write(input logic [7:0] d, input logic [1:0] a, input logic [3:0] s, input logic b);
    int         k;
    logic [7:0] gotData;
    logic [1:0] gotAddr;
    logic [3:0] gotSel;
    logic       gotBusy;
    for (k = 0; k < 200 && seenData.size() == 0; k++) @(posedge core_clk);
    `CHECK("write count", 1, seenData.size() > 0)
    if (seenData.size() > 0) begin
      // Pop once; the compare macro reads its argument twice
      gotData = seenData.pop_front();
      gotAddr = seenAddr.pop_front();
      gotSel  = seenSel.pop_front();
      gotBusy = seenBusy.pop_front();
      `CHECK("ram data", d, gotData)
      `CHECK("ram addr", a, gotAddr)
      `CHECK("chip select", s, gotSel)
      `CHECK("busy during write", b, gotBusy)
    end
  endtask : expect_write

  task test_counter_wrap();
    logic [7:0] w[5];
    int         i;
    w = '{8'h3C, 8'h81, 8'hFF, 8'h00, 8'h5A};
    jtag_host_model_i.shift_bits(w[0], 7, 1'h0);
    repeat (40) @(posedge core_clk);
    `CHECK("early write", 0, seenData.size())
    jtag_host_model_i.shift_bits(w[0] >> 7, 1, 1'h0);
    expect_write(w[0], 2'h0, 4'h1, 1'h1);
    for (i = 1; i < 5; i++) begin
      jtag_host_model_i.shift_bits(w[i], 8, 1'h0);
      expect_write(w[i], i[1:0], (i < 4) ? 4'h1 : 4'h2, 1'h1);
    end
  endtask : test_counter_wrap

  task test_ext_addr();
    @(posedge core_clk);
    useExtAddr <= 1'h1;
    jtag_host_model_i.shift_bits(8'h02, 2, 1'h1);
    jtag_host_model_i.pulse_update();
    jtag_host_model_i.shift_bits(8'hC3, 8, 1'h0);
    expect_write(8'hC3, 2'h2, 4'h2, 1'h1);
    @(posedge core_clk);
    useExtAddr <= 1'h0;
  endtask : test_ext_addr

  task test_user_port();
    int k;
    @(posedge core_clk);
    userWrEn    <= 1'h1;
    userWrAddr  <= 2'h1;
    userWrData  <= 8'hA5;
    userChipSel <= 4'h8;
    for (k = 0; k < 10 && ramWrData !== 8'hA5; k++) @(posedge core_clk);
    `CHECK("user data", 8'hA5, ramWrData)
    `CHECK("user select", 4'h8, ramChipSel)
    `CHECK("busy", 1'h0, loadBusy)
    `CHECK("user addr", 2'h1, ramWrAddr)
    expect_write(8'hA5, 2'h1, 4'h8, 1'h0);
    userWrEn <= 1'h0;
    repeat (4) @(posedge core_clk);
  endtask : test_user_port

  task final_report();
    $display("checks %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge core_clk);
    nErrors++;
    final_report();
  end

  initial begin
    {rst_b, useExtAddr, userWrEn, userWrAddr, userWrData, userChipSel} = '0;
    repeat (8) @(posedge core_clk);
    `CHECK("reset outputs", 16'h0, {ramWrData, ramWrAddr, ramChipSel, ramWrClk, loadBusy})
    repeat (8) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    test_counter_wrap();
    test_ext_addr();
    test_user_port();
    final_report();
  end
endmodule : ram_init_loader_bench
